// [rtl/clock_network_control_block.v]
`timescale 1ns/1ps
`include "clock_ctrl_map.vh"
// Behaviour
// - one control unit per global, regional and pll output network.
// - every unit selects a source and can stop or start it at run time.
// - global source comes from static config or run-time select.
// - static selection may pick any multiplexer input.
// - run-time global selection toggles between two configured inputs only.
// - regional and pll output units take static selection only.
// - pll output selects are fixed by configuration, ignoring user mode control.
// - pll output pin carries either user signal or control unit output.
// - eight regional networks, fed by pins, pll outputs or internal logic.
// - each top positive pin feeds delay line, two globals, two regionals four apart.
// - each internal global driver reaches one global; regional drivers two, four apart.
// - fast pll switchover is manual only.
module clock_network_control_block (
  input wire clk,
  input wire rstn,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire config_done,
  input wire [3:0] top_dedicated_pin_positive,
  input wire [3:0] top_dedicated_pin_negative,
  input wire [1:0] pll_counter_output,
  input wire [3:0] internal_global_driver,
  input wire [7:0] internal_regional_driver,
  input wire [3:0] global_dyn_sel,
  input wire [3:0] global_enable,
  input wire [7:0] regional_enable,
  input wire pllout_enable,
  input wire pllout_user_signal,
  input wire fast_pll_manual_switch,
  output wire [3:0] top_global_network,
  output wire [7:0] regional_network,
  output reg delay_loop_clock_line,
  output wire pll_out_pin,
  output reg fast_pll_ref_sel_r
);
  reg [31:0] global_cfg_r;
  reg [31:0] regional_cfg_r;
  reg [31:0] pllout_cfg_r;
  reg [31:0] enable_r;
  reg cfg_locked_r;
  wire [3:0] g_run;
  wire [7:0] r_run;
  wire p_run;
  wire pll_unit_clk;
  wire [2:0] pll_sel;

  // configuration writes only land before user mode; afterwards locked
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      global_cfg_r <= 32'h00000000;
      regional_cfg_r <= 32'h00000000;
      pllout_cfg_r <= 32'h00000000;
      enable_r <= `ENABLE_RESET;
      cfg_locked_r <= 1'b0;
    end else begin
      if (config_done) begin
        cfg_locked_r <= 1'b1;
      end
      if (reg_wr && !cfg_locked_r) begin
        if (reg_addr == `REG_GLOBAL_CFG) begin
          global_cfg_r <= reg_wdata;
        end else if (reg_addr == `REG_REGIONAL_CFG) begin
          regional_cfg_r <= reg_wdata;
        end else if (reg_addr == `REG_PLLOUT_CFG) begin
          pllout_cfg_r <= reg_wdata;
        end
      end
      if (reg_wr && reg_addr == `REG_ENABLE) begin
        enable_r <= reg_wdata;
      end
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr == `REG_GLOBAL_CFG) begin
        reg_rdata <= global_cfg_r;
      end else if (reg_addr == `REG_REGIONAL_CFG) begin
        reg_rdata <= regional_cfg_r;
      end else if (reg_addr == `REG_PLLOUT_CFG) begin
        reg_rdata <= pllout_cfg_r;
      end else if (reg_addr == `REG_ENABLE) begin
        reg_rdata <= enable_r;
      end else if (reg_addr == `REG_STATUS) begin
        reg_rdata <= {16'h0000, cfg_locked_r, p_run, r_run, 1'b0, 1'b0, g_run};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `NUM_GLOBAL; i = i + 1) begin : g_global
      // pin pairs: pins 0,1 feed globals 0,1; pins 2,3 feed globals 2,3
      wire [7:0] src;
      wire [2:0] a_sel;
      wire [2:0] b_sel;
      wire [2:0] st_sel;
      wire [2:0] sel;
      assign src = {pll_counter_output, internal_global_driver[i],
        top_dedicated_pin_negative[i],
        top_dedicated_pin_positive[(i/2)*2+1], top_dedicated_pin_positive[(i/2)*2],
        2'b00};
      assign st_sel = global_cfg_r[`GCFG_STATIC_LSB +: 3];
      assign a_sel = global_cfg_r[`GCFG_PAIR_A_LSB +: 3];
      assign b_sel = global_cfg_r[`GCFG_PAIR_B_LSB +: 3];
      // run-time select picks one of exactly two inputs
      assign sel = global_cfg_r[`GCFG_DYN_BIT] ?
        (global_dyn_sel[i] ? b_sel : a_sel) : st_sel;
      clock_gate_unit u_unit (
        .clk(clk),
        .rstn(rstn),
        .src_in(src),
        .sel(sel),
        .enable(global_enable[i] & enable_r[`EN_GLOBAL_LSB + i]),
        .clk_out(top_global_network[i]),
        .running_r(g_run[i])
      );
    end
    for (i = 0; i < `NUM_REGIONAL; i = i + 1) begin : g_regional
      // regional k and k+4 share the same pin and driver pool
      wire [7:0] src;
      assign src = {pll_counter_output, internal_regional_driver[i % 4],
        internal_regional_driver[(i % 4) + 4],
        top_dedicated_pin_negative[i % 4], top_dedicated_pin_positive[i % 4],
        2'b00};
      clock_gate_unit u_unit (
        .clk(clk),
        .rstn(rstn),
        .src_in(src),
        .sel(regional_cfg_r[3*i +: 3]),
        .enable(regional_enable[i] & enable_r[`EN_REGIONAL_LSB + i]),
        .clk_out(regional_network[i]),
        .running_r(r_run[i])
      );
    end
  endgenerate

  assign pll_sel = pllout_cfg_r[2:0];
  clock_gate_unit u_pllout (
    .clk(clk),
    .rstn(rstn),
    .src_in({pll_counter_output, top_dedicated_pin_positive, 2'b00}),
    .sel(pll_sel),
    .enable(pllout_enable & enable_r[`EN_PLLOUT_BIT]),
    .clk_out(pll_unit_clk),
    .running_r(p_run)
  );
  assign pll_out_pin = pllout_cfg_r[`PCFG_PIN_SEL_BIT] ? pll_unit_clk :
    pllout_user_signal;

  // delay line gets the registered OR of the four positive top pins
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      delay_loop_clock_line <= 1'b0;
      fast_pll_ref_sel_r <= 1'b0;
    end else begin
      delay_loop_clock_line <= |top_dedicated_pin_positive;
      // switchover only on the manual level; no automatic path exists
      fast_pll_ref_sel_r <= fast_pll_manual_switch;
    end
  end
endmodule

// [rtl/clock_ctrl_map.vh]
`ifndef CLOCK_CTRL_MAP_VH
`define CLOCK_CTRL_MAP_VH

// register word offsets (byte address = offset)
`define REG_GLOBAL_CFG 4'h0
`define REG_REGIONAL_CFG 4'h4
`define REG_PLLOUT_CFG 4'h8
`define REG_ENABLE 4'hC
`define REG_STATUS 4'h1

// global config word: [2:0] static source, [3] dynamic mode,
// [6:4] dynamic pair input a, [10:8] dynamic pair input b
`define GCFG_STATIC_LSB 0
`define GCFG_DYN_BIT 3
`define GCFG_PAIR_A_LSB 4
`define GCFG_PAIR_B_LSB 8

// regional config: [3i+2:3i] source of network i; pll_out config: [2:0] source, [3] pin mux
`define PCFG_PIN_SEL_BIT 3

`define SEL_W 3
`define NUM_SRC 8
`define NUM_GLOBAL 4
`define NUM_REGIONAL 8
`define NUM_PLLOUT 1

// enable word: [3:0] global, [11:4] regional, [12] pll_out
`define EN_GLOBAL_LSB 0
`define EN_REGIONAL_LSB 4
`define EN_PLLOUT_BIT 12
`define ENABLE_RESET 32'h00001FFF

`endif

// [rtl/clock_gate_unit.v]
`timescale 1ns/1ps
// one control unit: source mux plus glitch-free gate
module clock_gate_unit (
  input wire clk,
  input wire rstn,
  input wire [7:0] src_in,
  input wire [2:0] sel,
  input wire enable,
  output wire clk_out,
  output reg running_r
);
  reg sel_src_r;
  reg en_meta_r;
  reg en_sync_r;
  reg gated_r;

  // sources are sampled on clk; one register stage keeps mux output clean
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_src_r <= 1'b0;
    end else begin
      sel_src_r <= src_in[sel];
    end
  end

  // enable is synchronised and only taken while the selected clock is low,
  // so a stop never truncates a high pulse
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_meta_r <= 1'b0;
      en_sync_r <= 1'b0;
      running_r <= 1'b0;
    end else begin
      en_meta_r <= enable;
      en_sync_r <= en_meta_r;
      if (!sel_src_r) begin
        running_r <= en_sync_r;
      end
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gated_r <= 1'b0;
    end else begin
      gated_r <= sel_src_r & running_r;
    end
  end

  assign clk_out = gated_r;
endmodule

// [test/clock_ctrl_chk.sv]
`timescale 1ns/1ps
module clock_ctrl_chk (
  input wire clk,
  input wire rstn,
  input wire [3:0] reg_addr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire [3:0] top_dedicated_pin_positive,
  input wire [3:0] global_enable,
  input wire [7:0] regional_enable,
  input wire fast_pll_manual_switch,
  input wire [3:0] top_global_network,
  input wire [7:0] regional_network,
  input wire delay_loop_clock_line,
  input wire fast_pll_ref_sel_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
  en_width_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 4'hC |-> reg_rdata[31:13] == 19'h0)
    else $error("enable word too wide");
  stat_width_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 4'h1 |-> reg_rdata[31:16] == 16'h0)
    else $error("status word too wide");
  unmapped_rd_a: assert property (
    $past(reg_rd) && $past(reg_addr) == 4'h2 |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  fast_copy_a: assert property (
    $past(rstn) |-> fast_pll_ref_sel_r == $past(fast_pll_manual_switch))
    else $error("fast pll select not manual copy");
  dll_or_a: assert property (
    $past(rstn) |-> delay_loop_clock_line == |$past(top_dedicated_pin_positive))
    else $error("delay line not fed by top pins");
  glob_off_a: assert property (
    (global_enable == 4'h0) [*8] |-> top_global_network == 4'h0)
    else $error("global network runs while disabled");
  reg_off_a: assert property (
    (regional_enable == 8'h00) [*8] |-> regional_network == 8'h00)
    else $error("regional network runs while disabled");
endmodule

// [test/user_clk_logic.sv]
`timescale 1ns/1ps
// toggling drivers so every gate always sees low phases to stop on
module user_clk_logic (
  input wire clk,
  input wire rstn,
  output reg [3:0] dyn_sel,
  output reg [3:0] gdrv,
  output reg [7:0] rdrv
);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dyn_sel <= 4'h0;
      gdrv <= 4'h0;
      rdrv <= 8'h00;
    end else begin
      dyn_sel <= ~dyn_sel;
      gdrv <= ~gdrv;
      rdrv <= ~rdrv;
    end
  end
endmodule

// [test/tb.sv]
`timescale 1ns/1ps
bind clock_network_control_block clock_ctrl_chk chk_i (.clk, .rstn, .reg_addr, .reg_rd,
  .reg_rdata, .top_dedicated_pin_positive, .global_enable, .regional_enable,
  .fast_pll_manual_switch, .top_global_network, .regional_network, .delay_loop_clock_line,
  .fast_pll_ref_sel_r);
module tb;
  reg clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, config_done = 0, pllout_enable = 1;
  reg pllout_user_signal = 1, fast_pll_manual_switch = 0;
  reg [3:0] reg_addr = 4'h0, top_dedicated_pin_positive = 4'h0, global_enable = 4'hF;
  reg [31:0] reg_wdata = 32'h0, q;
  reg [7:0] regional_enable = 8'hFF, cnt = 8'h00;
  reg [3:0] seen_lo = 4'h0;
  wire [31:0] reg_rdata;
  wire [3:0] top_global_network, global_dyn_sel, internal_global_driver;
  wire [7:0] regional_network, internal_regional_driver;
  wire delay_loop_clock_line, pll_out_pin, fast_pll_ref_sel_r;
  wire [3:0] top_dedicated_pin_negative = cnt[5:2];
  wire [1:0] pll_counter_output = cnt[1:0];
  int error_cnt = 0, compares = 0, i;
  reg [4:0] rows [0:3] = '{5'h00, 5'h03, 5'h10, 5'h19};
  always #2.5 clk = ~clk;
  always @(posedge clk) cnt <= cnt + 8'h01;
  user_clk_logic partner (.clk, .rstn, .dyn_sel(global_dyn_sel),
    .gdrv(internal_global_driver), .rdrv(internal_regional_driver));
  clock_network_control_block DUT (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .config_done, .top_dedicated_pin_positive, .top_dedicated_pin_negative,
    .pll_counter_output, .internal_global_driver, .internal_regional_driver, .global_dyn_sel,
    .global_enable, .regional_enable, .pllout_enable, .pllout_user_signal,
    .fast_pll_manual_switch, .top_global_network, .regional_network, .delay_loop_clock_line,
    .pll_out_pin, .fast_pll_ref_sel_r);
  task chk(input string n, input [31:0] got, input [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, exp, got);
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task report_and_stop;
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #5000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    #3 chk("rst_glob", top_global_network, 4'h0);
    chk("rst_pll", pll_out_pin, 1'b1);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    pllout_user_signal <= 1'b0;
    rd(4'hC);
    chk("en_rst", q, 32'h1FFF);
    rd(4'h2);
    chk("unmapped", q, 32'h0);
    rd(4'h1);
    chk("stat_hi", q[31:16], 16'h0);
    wr(4'h0, 32'h5);
    wr(4'h4, 32'hB6DB6D);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      {top_dedicated_pin_positive, fast_pll_manual_switch} <= rows[i];
      @(posedge clk);
      #1 chk("dll", delay_loop_clock_line, |rows[i][4:1]);
      chk("fast", fast_pll_ref_sel_r, rows[i][0]);
    end
    // port and register both off, so either path alone stopping the clocks would pass here
    wr(4'hC, 32'h0);
    global_enable <= 4'h0;
    regional_enable <= 8'h00;
    repeat (12) @(posedge clk);
    #1 chk("glob_off", top_global_network, 4'h0);
    chk("reg_off", regional_network, 8'h00);
    wr(4'hC, 32'h1FFF);
    global_enable <= 4'hF;
    regional_enable <= 8'hFF;
    q = 32'h0;
    repeat (20) begin
      @(posedge clk);
      #1 q = q | {top_global_network, regional_network};
    end
    chk("resume", q, 32'hFFF);
    // pair a is a tied-low input, pair b the upper pin of each half
    wr(4'h0, 32'h308);
    repeat (3) @(posedge clk);
    q = 32'h0;
    repeat (8) begin
      @(posedge clk);
      #1 q = q | top_global_network;
      seen_lo = seen_lo | ~top_global_network;
    end
    chk("dyn_hi", q, 32'hC);
    chk("dyn_lo", seen_lo, 4'hF);
    wr(4'h8, 32'hD);
    repeat (4) @(posedge clk);
    #1 chk("pll_unit", pll_out_pin, 1'b1);
    @(posedge clk);
    config_done <= 1'b1;
    wr(4'h8, 32'h5);
    repeat (4) @(posedge clk);
    #1 chk("pll_lock", pll_out_pin, 1'b1);
    rd(4'h8);
    chk("pll_cfg_kept", q, 32'hD);
    rd(4'h1);
    chk("locked", q[15], 1'b1);
    report_and_stop;
  end
endmodule
